// ### tsi_pkg.sv
// Overview of operation
// RULE_01: Start in SPI mode; any received UART byte locks UART mode until reset.
// RULE_02: Never transmit unsolicited; bytes go out only as answers to host commands.
// RULE_03: Every received command produces some response byte.
// RULE_04: Return-last-command code is answered with its bitwise complement.
// RULE_05: Host starts a byte only while the ready line is high.
// RULE_06: After each received byte pull ready low within 20us, for at least 1us; the code holds it low for 39 cycles (975ns).
// RULE_07: Host waits 20us then for ready high before the next byte.
// RULE_08: Release ready within 1ms of a command; 20ms setups/CRC, 5ms sleep.
// RULE_09: After reset hold ready low for at least 1ms.
// RULE_10: UART mode: ready is wired-AND; withhold responses while host holds it low.
// RULE_11: SPI mode: ready is open-drain with pull-up, idles high, means ready.
// RULE_12: SPI slave, clock idles high, shift on falling, sample on rising, max 4MHz; the bench host model clocks SCK with a 30ns period.
// RULE_13: Host holds select low across each byte and high when idle.
// RULE_14: MISO floats whenever slave select is high.
// RULE_15: Host clocks pending responses out with null bytes before a new command.
// RULE_16: Non-null bytes during intermediate response shift-out are ignored.
// RULE_17: Sleep command sleeps; wake input low for 10us wakes the device.
// RULE_18: With select tied to wake, host wakes by holding select low 10us.
// RULE_19: Host polls report-first-key at most every 10ms; streaming runs full rate.
// RULE_20: Host uses all-keys and error queries only when flagged.
// RULE_21: UART frame: one start, eight data, no parity, one stop bit.
// RULE_22: Abandon a multi-byte transfer silently when no byte arrives within 100ms.
// RULE_23: Multi-byte values go least significant byte first.
// RULE_24: SPI bytes are eight bits MSB first; bit counter restarts while select high.
package tsi_pkg;

  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SPI_MAX_HZ      = 4_000_000;
  localparam int BAUD_HZ         = 115_200;

  // Times in their own units
  localparam int T_RDY_LOW_NS    = 1_000;
  localparam int T_RDY_LATE_NS   = 20_000;
  localparam int T_WAKE_NS       = 10_000;
  localparam int T_RESP_US       = 1_000;
  localparam int T_RESP_LONG_US  = 20_000;
  localparam int T_RESP_SLEEP_US = 5_000;
  localparam int T_RST_HOLD_US   = 1_000;
  localparam int T_BYTE_GAP_US   = 100_000;

  // Least times round up, longest times round down
  localparam int RDY_LOW_CYC   = (T_RDY_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RDY_LATE_CYC  = T_RDY_LATE_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYC      = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESP_CYC      = T_RESP_US * 1000 / CLK_PERIOD_NS;
  localparam int RESP_LONG_CYC = T_RESP_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int RESP_SLP_CYC  = T_RESP_SLEEP_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_HOLD_CYC  = (T_RST_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_GAP_CYC  = T_BYTE_GAP_US / CLK_PERIOD_NS * 1000;
  localparam int BAUD_DIV      = CLK_HZ / BAUD_HZ;

  localparam int TMR_W  = 23;
  localparam int BAUD_W = 16;

  // Command and response codes
  localparam logic [7:0] CMD_NULL     = 8'h00;
  localparam logic [7:0] CMD_SETUPS   = 8'h01;
  localparam logic [7:0] CMD_EE_CRC   = 8'h0E;
  localparam logic [7:0] CMD_GET_LAST = 8'h0F;
  localparam logic [7:0] CMD_SLEEP    = 8'h16;
  localparam logic [7:0] RESP_FAIL    = 8'h00;

  // Synchroniser lanes and their reset levels
  localparam int         SY_DONE   = 0;
  localparam int         SY_RX     = 1;
  localparam int         SY_RDY    = 2;
  localparam int         SY_WAKE   = 3;
  localparam logic [3:0] SYNC_RST  = 4'hE;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tsi_cmd_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tsi_resp_s;

  typedef enum logic [2:0] {S_HOLD, S_IDLE, S_WAIT, S_RESP, S_SEND, S_SLEEP} tsi_state_e;

endpackage : tsi_pkg

// ### tsi_host_port.sv
`timescale 1ns/10ps
module tsi_host_port #(
  parameter int RESP_CYC      = tsi_pkg::RESP_CYC,
  parameter int RESP_LONG_CYC = tsi_pkg::RESP_LONG_CYC,
  parameter int RESP_SLP_CYC  = tsi_pkg::RESP_SLP_CYC,
  parameter int RST_HOLD_CYC  = tsi_pkg::RST_HOLD_CYC,
  parameter int BYTE_GAP_CYC  = tsi_pkg::BYTE_GAP_CYC
) (
  // Core clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // SPI link
  input  wire logic         sck,
  input  wire logic         ss_n,
  input  wire logic         mosi,
  output logic              miso_o,
  output logic              miso_oe,
  // UART link
  input  wire logic         rx,
  output logic              tx_o,
  output logic              tx_oe,
  // Ready handshake, open drain
  input  wire logic         ready_handshake_i,
  output logic              ready_handshake_o,
  output logic              ready_handshake_oe,
  // Wake input, low wakes
  input  wire logic         wake_sync_input,
  // Command side
  output tsi_pkg::tsi_cmd_s cmd,
  output logic              resp_req,
  input  tsi_pkg::tsi_resp_s resp,
  output logic              uart_mode,
  output logic              asleep
);
  import tsi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tsi_state_e       st_q, st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [5:0]       low_q, low_d;
  logic [8:0]       wake_q, wake_d;
  logic             lock_q, lock_d;
  logic             more_q, more_d;
  logic             slp_q, slp_d;
  logic             asleep_q, asleep_d;
  logic [7:0]       txb_q, txb_d;
  tsi_cmd_s         cmd_q, cmd_d;
  logic             req_q, req_d;
  logic             rdy_oe_q, rdy_oe_d;
  logic             rdy_o_q;
  logic             iss;
  logic             utx_go;
  logic             rx_evt;
  logic [7:0]       rx_byte;

  logic [3:0]       s1_q, s2_q, s3_q, cl_q, cl_d;
  logic             spi_evt;
  logic             rx_fall;

  logic              ubusy_q, ubusy_d;
  logic [BAUD_W-1:0] ucnt_q, ucnt_d;
  logic [3:0]        ubit_q, ubit_d;
  logic [7:0]        ush_q, ush_d;
  logic              urx_evt;

  logic              tbusy_q, tbusy_d;
  logic [BAUD_W-1:0] tcnt_q, tcnt_d;
  logic [3:0]        tbit_q, tbit_d;
  logic [9:0]        tsh_q, tsh_d;
  logic              tx_q, tx_d;
  logic              txoe_q, txoe_d;
  logic              utx_done;

  logic [2:0]       sbit_q;
  logic             sdone_q;
  logic [7:0]       ssh_q, shold_q;
  logic             miso_q, miso_oe_q, slk1_q, slk2_q;

  function automatic logic [TMR_W-1:0] resp_limit(input logic [7:0] c);
    if (c == CMD_SETUPS || c == CMD_EE_CRC) begin
      resp_limit = TMR_W'(RESP_LONG_CYC - 1);
    end else if (c == CMD_SLEEP) begin
      resp_limit = TMR_W'(RESP_SLP_CYC - 1);
    end else begin
      resp_limit = TMR_W'(RESP_CYC - 1);
    end
  endfunction : resp_limit

  ////////////////////////////////////////////////////////////////////////////
  // SPI link domain, mode 3, MSB first
  // Select high clears the frame asynchronously; SCK may stand still between bytes
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      sbit_q  <= 3'd0;                                   // see RULE_24
    end else begin
      sbit_q  <= sbit_q + 3'd1;
    end
  end

  // Done stands until the next frame's first edge, long enough for the core filter
  always_ff @(posedge sck) begin
    sdone_q <= (sbit_q == 3'd7);                         // see RULE_24
    ssh_q <= {ssh_q[6:0], mosi};                         // see RULE_12
    if (sbit_q == 3'd7) begin
      shold_q <= {ssh_q[6:0], mosi};
    end
  end

  // Limitation: after UART lock, the first two bits of a stray frame may still drive
  always_ff @(negedge sck or posedge ss_n) begin
    if (ss_n) begin
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;                                 // see RULE_14
      slk1_q    <= 1'b0;
      slk2_q    <= 1'b0;
    end else begin
      slk1_q    <= lock_q;
      slk2_q    <= slk1_q;
      miso_oe_q <= ~slk2_q;                              // see RULE_01
      miso_q    <= txb_q[~sbit_q];                       // see RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a change counts once stages two and three agree
  always_comb begin
    cl_d    = (s2_q & s3_q) | (cl_q & (s2_q | s3_q));
    spi_evt = cl_d[SY_DONE] & ~cl_q[SY_DONE];
    rx_fall = ~cl_d[SY_RX] & cl_q[SY_RX];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      cl_q <= SYNC_RST;
    end else begin
      s1_q <= {wake_sync_input, ready_handshake_i, rx, sdone_q};
      s2_q <= s1_q;
      s3_q <= s2_q;
      cl_q <= cl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // UART receiver, 8N1, LSB first
  always_comb begin
    ubusy_d = ubusy_q;
    ucnt_d  = ucnt_q;
    ubit_d  = ubit_q;
    ush_d   = ush_q;
    urx_evt = 1'b0;
    if (!ubusy_q) begin
      if (rx_fall) begin
        ubusy_d = 1'b1;
        ucnt_d  = BAUD_W'(BAUD_DIV / 2);
        ubit_d  = 4'd0;
      end
    end else if (ucnt_q != '0) begin
      ucnt_d = ucnt_q - 1'b1;
    end else begin
      ucnt_d = BAUD_W'(BAUD_DIV - 1);
      ubit_d = ubit_q + 4'd1;
      if (ubit_q == 4'd0 && cl_q[SY_RX]) begin
        ubusy_d = 1'b0;                                  // Glitch, not a start bit
      end else if (ubit_q == 4'd9) begin
        ubusy_d = 1'b0;
        urx_evt = cl_q[SY_RX];                           // see RULE_21
      end else if (ubit_q != 4'd0) begin
        ush_d = {cl_q[SY_RX], ush_q[7:1]};               // see RULE_21
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ubusy_q <= 1'b0;
      ucnt_q  <= '0;
      ubit_q  <= 4'd0;
      ush_q   <= 8'h00;
    end else begin
      ubusy_q <= ubusy_d;
      ucnt_q  <= ucnt_d;
      ubit_q  <= ubit_d;
      ush_q   <= ush_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // UART transmitter; floats once the stop bit ends for multi-drop use
  always_comb begin
    tbusy_d  = tbusy_q;
    tcnt_d   = tcnt_q;
    tbit_d   = tbit_q;
    tsh_d    = tsh_q;
    tx_d     = tx_q;
    txoe_d   = txoe_q;
    utx_done = 1'b0;
    if (!tbusy_q) begin
      tx_d   = 1'b1;
      txoe_d = 1'b0;
      if (utx_go) begin
        tbusy_d = 1'b1;
        tsh_d   = {1'b1, txb_q, 1'b0};                   // see RULE_21
        tcnt_d  = BAUD_W'(BAUD_DIV - 1);
        tbit_d  = 4'd0;
        tx_d    = 1'b0;
        txoe_d  = 1'b1;
      end
    end else if (tcnt_q != '0) begin
      tcnt_d = tcnt_q - 1'b1;
    end else if (tbit_q == 4'd9) begin
      tbusy_d  = 1'b0;
      utx_done = 1'b1;
      tx_d     = 1'b1;
      txoe_d   = 1'b0;
    end else begin
      tbit_d = tbit_q + 4'd1;
      tcnt_d = BAUD_W'(BAUD_DIV - 1);
      tx_d   = tsh_q[1];
      tsh_d  = {1'b0, tsh_q[9:1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tbusy_q <= 1'b0;
      tcnt_q  <= '0;
      tbit_q  <= 4'd0;
      tsh_q   <= 10'h3FF;
      tx_q    <= 1'b1;
      txoe_q  <= 1'b0;
    end else begin
      tbusy_q <= tbusy_d;
      tcnt_q  <= tcnt_d;
      tbit_q  <= tbit_d;
      tsh_q   <= tsh_d;
      tx_q    <= tx_d;
      txoe_q  <= txoe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command and response pacing
  always_comb begin
    st_d    = st_q;
    tmr_d   = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    low_d   = (low_q != 6'd0) ? low_q - 6'd1 : low_q;
    wake_d  = wake_q;
    lock_d  = lock_q | urx_evt;                          // see RULE_01
    more_d  = more_q;
    slp_d   = slp_q;
    txb_d   = txb_q;
    cmd_d   = cmd_q;
    cmd_d.valid = 1'b0;
    iss     = 1'b0;
    // SPI bytes are dropped for good once UART has been seen
    rx_evt  = urx_evt | (spi_evt & ~lock_q);             // see RULE_01
    rx_byte = urx_evt ? ush_q : shold_q;
    // Ready falls right after any byte; the host must leave 20us for this
    if (rx_evt) begin
      low_d = 6'(RDY_LOW_CYC - 1);                       // see RULE_06
    end
    // Host clamp on the wire-AND line holds a pending answer back
    utx_go = (st_q == S_RESP) & lock_q & cl_q[SY_RDY]    // see RULE_02, RULE_10
           & (low_q == 6'd0) & ~tbusy_q;
    case (st_q)
      S_HOLD: begin
        if (tmr_q == '0) begin
          st_d = S_IDLE;                                 // see RULE_09
        end
      end
      S_IDLE: begin
        iss = rx_evt & (rx_byte != CMD_NULL);
      end
      S_WAIT: begin
        if (resp.valid) begin
          txb_d  = resp.data;                            // see RULE_23
          more_d = ~resp.last;
          st_d   = S_RESP;
          tmr_d  = TMR_W'(BYTE_GAP_CYC - 1);
        end else if (tmr_q == '0) begin
          txb_d  = RESP_FAIL;                            // see RULE_03
          more_d = 1'b0;
          st_d   = S_RESP;
          tmr_d  = TMR_W'(BYTE_GAP_CYC - 1);
        end
      end
      S_RESP: begin
        if (utx_go) begin
          st_d = S_SEND;                                 // see RULE_10
        end else if (!lock_q && rx_evt) begin
          if (more_q) begin
            st_d  = S_WAIT;                              // see RULE_16
            tmr_d = TMR_W'(RESP_CYC - 1);
          end else if (slp_q) begin
            st_d = S_SLEEP;
          end else begin
            st_d = S_IDLE;
            iss  = (rx_byte != CMD_NULL);
          end
        end else if (!lock_q && more_q && tmr_q == '0) begin
          st_d = S_IDLE;                                 // see RULE_22
        end
      end
      S_SEND: begin
        if (utx_done) begin
          if (more_q) begin
            st_d  = S_WAIT;
            tmr_d = TMR_W'(RESP_CYC - 1);
          end else begin
            st_d = slp_q ? S_SLEEP : S_IDLE;
          end
        end
      end
      S_SLEEP: begin
        wake_d = cl_q[SY_WAKE] ? 9'd0 : wake_q + 9'd1;
        if (wake_q == 9'(WAKE_CYC - 1) && !cl_q[SY_WAKE]) begin
          st_d   = S_IDLE;                               // see RULE_17
          slp_d  = 1'b0;
          wake_d = 9'd0;
        end
      end
      default: begin
        st_d = S_HOLD;
      end
    endcase
    if (iss) begin
      cmd_d.data = rx_byte;
      slp_d      = (rx_byte == CMD_SLEEP);               // see RULE_17
      if (rx_byte == CMD_GET_LAST) begin
        txb_d  = ~rx_byte;                               // see RULE_04
        more_d = 1'b0;
        st_d   = S_RESP;
        tmr_d  = TMR_W'(BYTE_GAP_CYC - 1);
      end else begin
        cmd_d.valid = 1'b1;                              // see RULE_03
        st_d        = S_WAIT;
        tmr_d       = resp_limit(rx_byte);               // see RULE_08
      end
    end
    req_d    = (st_d == S_WAIT);
    asleep_d = (st_d == S_SLEEP);
    // Open drain: driving means low; released only when idle or answer waits
    rdy_oe_d = ~(((st_d == S_IDLE) | (st_d == S_RESP)) & (low_d == 6'd0)); // see RULE_11
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q     <= S_HOLD;
      tmr_q    <= TMR_W'(RST_HOLD_CYC - 1);
      low_q    <= 6'd0;
      wake_q   <= 9'd0;
      lock_q   <= 1'b0;
      more_q   <= 1'b0;
      slp_q    <= 1'b0;
      txb_q    <= 8'h00;
      cmd_q    <= '0;
      req_q    <= 1'b0;
      asleep_q <= 1'b0;
      rdy_oe_q <= 1'b1;
      rdy_o_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      tmr_q    <= tmr_d;
      low_q    <= low_d;
      wake_q   <= wake_d;
      lock_q   <= lock_d;
      more_q   <= more_d;
      slp_q    <= slp_d;
      txb_q    <= txb_d;
      cmd_q    <= cmd_d;
      req_q    <= req_d;
      asleep_q <= asleep_d;
      rdy_oe_q <= rdy_oe_d;
      rdy_o_q  <= 1'b0;
    end
  end

  assign miso_o             = miso_q;
  assign miso_oe            = miso_oe_q;
  assign tx_o               = tx_q;
  assign tx_oe              = txoe_q;
  assign ready_handshake_o  = rdy_o_q;
  assign ready_handshake_oe = rdy_oe_q;
  assign cmd                = cmd_q;
  assign resp_req           = req_q;
  assign uart_mode          = lock_q;
  assign asleep             = asleep_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  uart_lock_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_01
    lock_q |=> lock_q) else $error("UART lock was lost");
  spi_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_01
    (lock_q && spi_evt && !urx_evt) |=> !cmd_q.valid) else $error("SPI byte used in UART mode");
  no_unsolicited_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_02
    $rose(txoe_q) |-> $past(st_q == S_RESP)) else $error("UART sent without an answer pending");
  echo_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_04
    (iss && rx_byte == CMD_GET_LAST) |=> (txb_q == 8'hF0) && (st_q == S_RESP))
    else $error("Get-last-command answer is not the complement");
  low_after_byte_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_06
    (rx_evt && st_q != S_HOLD) |=> rdy_oe_q [*8]) else $error("Ready not held low after byte");
  wait_deadline_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_08
    (st_q == S_WAIT && tmr_q == '0 && !resp.valid) |=> (st_q == S_RESP) && (txb_q == RESP_FAIL))
    else $error("Response deadline missed");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_09
    (st_q == S_HOLD) |-> rdy_oe_q) else $error("Ready released during reset hold");
  withhold_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_10
    $rose(tbusy_q) |-> $past(cl_q[SY_RDY])) else $error("UART sent while host clamps ready");
  ignore_mid_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_16
    (st_q == S_RESP && more_q && !lock_q && rx_evt) |=> !cmd_q.valid && st_q == S_WAIT)
    else $error("Command taken during intermediate shift-out");
  wake_a: assert property (@(posedge core_clk) disable iff (!resetn) // see RULE_17
    (st_q == S_SLEEP && cl_q[SY_WAKE]) |=> st_q == S_SLEEP) else $error("Woke without low wake");

endmodule : tsi_host_port

// ### tsi_host_model.sv
`timescale 1ns/10ps
module tsi_host_model (
  // Request from the bench
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  output logic            done,
  output logic [7:0]      rx_byte,
  // SPI wires, master side
  output logic            sck,
  output logic            ss_n,
  output logic            mosi,
  input  wire logic       miso_w,
  input  wire logic       rdy_w
);
  initial begin
    sck     = 1'b1;
    mosi    = 1'b0;
    done    = 1'b0;
    rx_byte = 8'h00;
    // Select rises once the port waits on it; one idle clock settles its frame flops
    #1 ss_n = 1'b1;
    #5 sck = 1'b0;
    #15 sck = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge go) begin
    wait (rdy_w === 1'b1);
    #7 ss_n = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) begin
      sck  = 1'b0;
      mosi = tx_byte[i];
      #15 sck = 1'b1;
      rx_byte[i] = miso_w;
      #15;
    end
    // Select rises only once the clock is back high
    #20 ss_n = 1'b1;
    mosi = ~mosi;
    #20_000 done = 1'b1;
    wait (go == 1'b0);
    done = 1'b0;
  end
endmodule : tsi_host_model

// ### testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import tsi_pkg::*;
  logic core_clk, resetn, sck, ss_n, mosi, miso_o, miso_oe, rx, tx_o, tx_oe;
  logic rdy_o, rdy_oe, rdy_w, wake, resp_req, uart_mode, asleep, miso_w, miso_last;
  logic go, done, rdy_fell, host_clamp;
  logic [7:0] tx_byte, rx_byte, r, cmd_last;
  int bad_count, n_compared, cmd_cnt;
  tsi_cmd_s  cmd;
  tsi_resp_s resp;

  // Pull-up on the ready line; released MISO shows the inverse of its last bit
  assign rdy_w  = ~rdy_oe & ~host_clamp;
  assign miso_w = miso_oe ? miso_o : ~miso_last;

  tsi_host_port #(.RESP_CYC(2000), .RESP_LONG_CYC(4000), .RESP_SLP_CYC(3000),
    .RST_HOLD_CYC(100), .BYTE_GAP_CYC(500)) i_tsi_host_port (
    .core_clk(core_clk), .resetn(resetn), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .rx(rx), .tx_o(tx_o), .tx_oe(tx_oe),
    .ready_handshake_i(rdy_w), .ready_handshake_o(rdy_o), .ready_handshake_oe(rdy_oe),
    .wake_sync_input(wake), .cmd(cmd), .resp_req(resp_req), .resp(resp),
    .uart_mode(uart_mode), .asleep(asleep));

  tsi_host_model i_tsi_host_model (.go(go), .tx_byte(tx_byte), .done(done),
    .rx_byte(rx_byte), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_w(miso_w), .rdy_w(rdy_w));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (miso_oe) miso_last <= miso_o;
    if (cmd.valid) begin
      cmd_cnt  <= cmd_cnt + 1;
      cmd_last <= cmd.data;
    end
  end
  always @(negedge rdy_w) rdy_fell = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic spi_xfer(input logic [7:0] b, output logic [7:0] got);
    @(posedge core_clk);
    tx_byte <= b;
    go      <= 1'b1;
    rdy_fell = 1'b0;
    wait (done === 1'b1);
    got = rx_byte;
    @(posedge core_clk);
    go <= 1'b0;
    wait (done === 1'b0);
  endtask : spi_xfer

  task automatic resp_give(input logic [7:0] d, input logic last);
    int n;
    n = 0;
    while (resp_req !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("resp_req", 1'b1, resp_req)
    @(posedge core_clk);
    resp <= '{valid: 1'b1, last: last, data: d};
    @(posedge core_clk);
    resp <= '0;
  endtask : resp_give

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_hold();
    repeat (95) @(posedge core_clk);
    `CHK("ready after reset", 1'b0, rdy_w)
    `CHK("ready drive level", 1'b0, rdy_o)
    repeat (20) @(posedge core_clk);
    `CHK("ready released", 1'b1, rdy_w)
  endtask : t_reset_hold

  task automatic t_get_last();
    int c;
    c = cmd_cnt;
    spi_xfer(CMD_GET_LAST, r);
    `CHK("ready pulsed low", 1'b1, rdy_fell)
    `CHK("miso floats", 1'b0, miso_oe)
    spi_xfer(CMD_NULL, r);
    `CHK("complement", 8'hF0, r)
    `CHK("internal cmd", c, cmd_cnt)
  endtask : t_get_last

  task automatic t_multi();
    int c;
    c = cmd_cnt;
    spi_xfer(8'h05, r);
    resp_give(8'h34, 1'b0);
    spi_xfer(8'h22, r);
    `CHK("low byte", 8'h34, r)
    resp_give(8'h12, 1'b1);
    spi_xfer(CMD_NULL, r);
    `CHK("high byte", 8'h12, r)
    `CHK("cmd count", c + 1, cmd_cnt)
    `CHK("cmd data", 8'h05, cmd_last)
  endtask : t_multi

  task automatic t_deadline();
    spi_xfer(8'h07, r);
    spi_xfer(CMD_NULL, r);
    `CHK("fail answer", RESP_FAIL, r)
    `CHK("no pending", 1'b0, resp_req)
  endtask : t_deadline

  task automatic t_sleep();
    spi_xfer(CMD_SLEEP, r);
    resp_give(8'hA5, 1'b1);
    spi_xfer(CMD_NULL, r);
    `CHK("sleep answer", 8'hA5, r)
    repeat (20) @(posedge core_clk);
    `CHK("asleep", 1'b1, asleep)
    wake <= 1'b0;
    repeat (WAKE_CYC / 2) @(posedge core_clk);
    wake <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK("short pulse", 1'b1, asleep)
    wake <= 1'b0;
    repeat (WAKE_CYC + 10) @(posedge core_clk);
    wake <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK("awake", 1'b0, asleep)
  endtask : t_sleep

  task automatic t_uart_lock();
    logic [9:0] fr;
    logic [9:0] got;
    int c;
    int n;
    fr = {1'b1, CMD_GET_LAST, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= fr[i];
      if (i == 0) begin
        host_clamp <= 1'b1;
      end
      repeat (BAUD_DIV) @(posedge core_clk);
    end
    repeat (50) @(posedge core_clk);
    `CHK("uart mode", 1'b1, uart_mode)
    `CHK("answer withheld", 1'b0, tx_oe)
    host_clamp <= 1'b0;
    n = 0;
    while (tx_oe !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    repeat (BAUD_DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = tx_o;
      repeat (BAUD_DIV) @(posedge core_clk);
    end
    `CHK("uart answer", {1'b1, 8'hF0, 1'b0}, got)
    `CHK("tx floats", 1'b0, tx_oe)
    c = cmd_cnt;
    spi_xfer(8'h05, r);
    repeat (20) @(posedge core_clk);
    `CHK("spi ignored", c, cmd_cnt)
    `CHK("miso off", 1'b0, miso_oe)
  endtask : t_uart_lock

  initial begin
    resetn = 1'b0;
    wake = 1'b1;
    rx = 1'b1;
    resp = '0;
    go = 1'b0;
    tx_byte = 8'h00;
    miso_last = 1'b0;
    cmd_cnt = 0;
    cmd_last = 8'h00;
    rdy_fell = 1'b0;
    host_clamp = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset_hold();
    t_get_last();
    t_multi();
    t_deadline();
    t_sleep();
    t_uart_lock();
    final_report();
  end

  // Some dozen bytes at about a thousand cycles each, plus two UART frames
  initial begin
    #1_000_000;
    bad_count++;
    final_report();
  end
endmodule : testbench
